// ==== src/lnk_top.v ====
// Link auto-negotiation control and status with AUI reflectometer registers.
`timescale 1ns/1ps
`include "lnk_defs.vh"
module lnk_top (
   input  wire        clk_sys,               // System clock, 10 MHz.
   input  wire        rst_n,                 // Asynchronous reset, active low.
   input  wire [15:0] reg_addr,              // Register offset.
   input  wire        reg_rd,                // Read strobe, one cycle.
   input  wire        reg_wr,                // Write strobe, one cycle.
   input  wire [15:0] reg_wdata,             // Write data.
   output reg  [15:0] reg_rdata,             // Read data, valid cycle after strobe.
   input  wire        flp_burst_in,          // Partner fast pulse burst seen, async.
   input  wire        partner_fdx_in,        // Partner advertises full duplex, async.
   input  wire        link_good_in,          // Receive side reports good link, async.
   input  wire        aui_tx_in,             // AUI transmit active, async.
   input  wire        aui_collision_in,      // AUI collision, async.
   input  wire        aui_carrier_loss_in,   // AUI loss of carrier, async.
   output reg         nlp_tx_en,             // Send normal link pulses.
   output reg         flp_tx_en,             // Send fast link pulse bursts.
   output reg         tx_enable,             // Twisted-pair transmitter enable.
   output reg         adv_fdx_out,           // Full duplex in advertised abilities.
   output reg         duplex_indicator_out   // Full duplex indicator drive.
);

   // Negotiation states, one-hot. OFF: negotiation not allowed, the line is quiet
   // or runs a forced mode. ABIL: ability detect, counting partner bursts. ACK:
   // enough bursts seen, waiting for the receive side to call the link good. DONE:
   // finished; losing the link sends the sequencer back to ability detect.
   localparam [3:0] ST_OFF   = 4'h1;
   localparam [3:0] ST_ABIL  = 4'h2;
   localparam [3:0] ST_ACK   = 4'h4;
   localparam [3:0] ST_DONE  = 4'h8;

   // Six asynchronous pins share one synchroniser loop.
   localparam integer NSYNC = 6;

   // Address match, shared by the read and write decoders.
   // Offsets are compared in full, so no alias of a register ever responds.
   function hit;
      input [15:0] a;
      input [15:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   // Synchroniser chains for the asynchronous pins.
   wire [NSYNC-1:0] pin_raw;
   reg  [NSYNC-1:0] sync1_r;
   reg  [NSYNC-1:0] sync2_r;
   reg  [NSYNC-1:0] sync3_r;
   wire [NSYNC-1:0] rise;

   // Bit order from zero: burst, partner full duplex, link good, transmit, collision, carrier.
   assign pin_raw = {aui_carrier_loss_in, aui_collision_in, aui_tx_in,
                     link_good_in, partner_fdx_in, flp_burst_in};

   // Every pin passes two flops; the third flop only serves the edge detector.
   // The chains reset to zero, the idle level of every pin, so no false edge
   // follows reset. Only the second flop reads the first.
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
               sync3_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= pin_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
               sync3_r[gi] <= sync2_r[gi];
            end
         end
         assign rise[gi] = sync2_r[gi] & ~sync3_r[gi];
      end
   endgenerate

   // Partner bursts and the reflectometer work on rising edges; the rest are levels.
   // Either fault stops the reflectometer, whichever arrives first.
   wire burst_p     = rise[0];
   wire partner_fdx = sync2_r[1];
   wire link_good   = sync2_r[2];
   wire aui_start_p = rise[3];
   wire aui_stop_p  = rise[4] | rise[5];

   // Control register fields. Only the defined bits are stored; the reserved
   // bits read back as zero and take no part in any decision.
   reg        restart_r;
   reg        adv_fdx_r;
   reg        neg_en_r;
   reg        npo_r;
   reg        force_fdx_r;

   // Status and negotiation state.
   // The burst counter only has to reach the threshold, so three bits suffice.
   reg [3:0]  state_r;
   reg [3:0]  state_nxt;
   reg [2:0]  burst_cnt_r;
   reg [2:0]  burst_cnt_nxt;
   reg        adv_lat_r;
   reg        adv_lat_nxt;
   reg        burst_seen_r;
   reg        burst_seen_nxt;
   reg        done_r;
   reg        done_nxt;
   reg        lost_r;
   reg        lost_nxt;
   reg        hdx_r;
   reg        hdx_nxt;
   reg        fdx_r;
   reg        fdx_nxt;

   wire       wr_ctrl = reg_wr & hit(reg_addr, `LNK_OFF_CTRL);
   wire       rd_tdr  = reg_rd & hit(reg_addr, `LNK_OFF_TDR);

   // Negotiation may only run when enabled and neither override is set.
   wire       neg_allowed = neg_en_r & ~npo_r & ~force_fdx_r;
   wire       restart_wr  = wr_ctrl & reg_wdata[`LNK_CTL_RESTART]
                            & ~reg_wdata[`LNK_CTL_NPO]
                            & ~reg_wdata[`LNK_CTL_FORCE_FDX];
   // A negotiation begins on entry to ability detect, or when a pending restart
   // re-enters ability detect from itself, so the advertisement is sampled anew.
   wire       neg_begin   = state_nxt[1] & (~state_r[1] | restart_r);

   wire [`LNK_TDR_W-1:0] tdr_count;

   // Reflectometer counter; a host read clears it after the value is captured.
   // Start and stop pass the same synchroniser delay, so the delay cancels out
   // of the measured interval.
   lnk_tdr u_tdr (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .start_p (aui_start_p),
      .stop_p  (aui_stop_p),
      .clear_p (rd_tdr),
      .count   (tdr_count)
   );

   // Control register writes. Restart is held until the negotiation it asks for
   // actually begins, so a request made while disabled is kept, not lost.
   // Clearing negotiation enable drops the sequencer to OFF at once; software is
   // expected to write restart with it, and that restart then waits here.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         restart_r   <= 1'b0;
         adv_fdx_r   <= 1'b0;
         neg_en_r    <= 1'b0;
         npo_r       <= 1'b0;
         force_fdx_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            adv_fdx_r   <= reg_wdata[`LNK_CTL_ADV_FDX];
            neg_en_r    <= reg_wdata[`LNK_CTL_NEG_EN];
            npo_r       <= reg_wdata[`LNK_CTL_NPO];
            force_fdx_r <= reg_wdata[`LNK_CTL_FORCE_FDX];
         end
         if (restart_wr) begin
            restart_r <= 1'b1;
         end else if (neg_begin) begin
            restart_r <= 1'b0;
         end
      end
   end

   // Negotiation sequencer and status flags.
   always @* begin
      state_nxt      = state_r;
      burst_cnt_nxt  = burst_cnt_r;
      adv_lat_nxt    = adv_lat_r;
      burst_seen_nxt = burst_seen_r;
      done_nxt       = done_r;
      lost_nxt       = lost_r;
      hdx_nxt        = hdx_r;
      fdx_nxt        = fdx_r;
      case (state_r)
         ST_OFF: begin
            // Leave as soon as the mode bits allow negotiation.
            if (neg_allowed) begin
               state_nxt = ST_ABIL;
            end
         end
         ST_ABIL: begin
            // Each synchronised burst edge counts; the threshold moves on to ACK.
            if (burst_p) begin
               burst_cnt_nxt = burst_cnt_r + 3'h1;
            end
            if (burst_cnt_r == `LNK_BURSTS_NEEDED) begin
               state_nxt = ST_ACK;
            end
         end
         ST_ACK: begin
            // The result is judged on the abilities latched at ability-detect entry.
            if (link_good) begin
               state_nxt = ST_DONE;
               done_nxt  = 1'b1;
               if (partner_fdx && adv_lat_r) begin
                  fdx_nxt = 1'b1;
               end else begin
                  hdx_nxt = 1'b1;
               end
            end
         end
         ST_DONE: begin
            // A link that was good has gone: record it and start over.
            if (!link_good) begin
               lost_nxt  = 1'b1;
               state_nxt = ST_ABIL;
            end
         end
         default: begin
            // An illegal code returns to OFF; the next cycle rebuilds from there.
            state_nxt = ST_OFF;
         end
      endcase

      // A forced restart throws the sequencer back to ability detect, from any
      // state including ability detect itself, so the abilities are sampled again.
      if (restart_r && neg_allowed) begin
         state_nxt = ST_ABIL;
      end
      if (!neg_allowed) begin
         state_nxt = ST_OFF;
      end

      // Clearing on restart request; entry to ability detect clears the rest. A
      // restart written as negotiation finishes wins: negotiation runs again anyway.
      if (restart_wr) begin
         done_nxt = 1'b0;
         hdx_nxt  = 1'b0;
         fdx_nxt  = 1'b0;
      end
      if (state_nxt[1] && (!state_r[1] || restart_r)) begin
         adv_lat_nxt    = adv_fdx_r;
         burst_cnt_nxt  = 3'h0;
         burst_seen_nxt = 1'b0;
         done_nxt       = 1'b0;
      end
      // A burst arriving as the flag is cleared still counts.
      // Bursts are ignored while negotiation is not allowed.
      if (burst_p && neg_allowed) begin
         burst_seen_nxt = 1'b1;
      end

      // Forced modes override whatever negotiation found. Once a forced mode is
      // cleared, its duplex status stays until a restart; half duplex also ends on a full duplex result.
      if (force_fdx_r) begin
         fdx_nxt = 1'b1;
         hdx_nxt = 1'b0;
      end else if (npo_r) begin
         hdx_nxt = 1'b1;
         fdx_nxt = 1'b0;
      end
      // Full duplex wins, so the two duplex flags never show together.
      if (fdx_nxt) begin
         hdx_nxt = 1'b0;
      end
   end

   // Sequencer flops. All status flags except busy live here, so a read sees
   // values that settled a full cycle earlier.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r      <= ST_OFF;
         burst_cnt_r  <= 3'h0;
         adv_lat_r    <= 1'b0;
         burst_seen_r <= 1'b0;
         done_r       <= 1'b0;
         lost_r       <= 1'b0;
         hdx_r        <= 1'b0;
         fdx_r        <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         burst_cnt_r  <= burst_cnt_nxt;
         adv_lat_r    <= adv_lat_nxt;
         burst_seen_r <= burst_seen_nxt;
         done_r       <= done_nxt;
         lost_r       <= lost_nxt;
         hdx_r        <= hdx_nxt;
         fdx_r        <= fdx_nxt;
      end
   end

   // Busy is derived, not stored, so it can never disagree with the state.
   // It drops the moment negotiation is disallowed, before the state follows.
   wire busy = neg_allowed & (state_r[1] | state_r[2]);

   // Line drive. With no mode bit set the line stays silent, so no link forms.
   // Bursts keep running in DONE so the partner keeps seeing our abilities; only
   // OFF silences them. nlp_tx_en and tx_enable lag the control bits by one register stage, the rest lag the sequencer flops by one.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         nlp_tx_en            <= 1'b0;
         flp_tx_en            <= 1'b0;
         tx_enable            <= 1'b0;
         adv_fdx_out          <= 1'b0;
         duplex_indicator_out <= 1'b0;
      end else begin
         nlp_tx_en            <= npo_r | force_fdx_r;
         flp_tx_en            <= neg_allowed & ~state_r[0];
         tx_enable            <= npo_r | force_fdx_r | neg_en_r;
         adv_fdx_out          <= adv_lat_r;
         duplex_indicator_out <= fdx_r;
      end
   end

   // Read mux; an unmapped offset returns zero.
   // The low six bits of every register carry its fixed code; reserved bits are zero.
   reg [15:0] rdata_nxt;
   always @* begin
      rdata_nxt = 16'h0000;
      if (hit(reg_addr, `LNK_OFF_TDR)) begin
         rdata_nxt = {tdr_count, `LNK_ID_TDR};
      end else if (hit(reg_addr, `LNK_OFF_CTRL)) begin
         rdata_nxt = {10'h000, `LNK_ID_CTRL};
         rdata_nxt[`LNK_CTL_RESTART]   = restart_r;
         rdata_nxt[`LNK_CTL_ADV_FDX]   = adv_fdx_r;
         rdata_nxt[`LNK_CTL_NEG_EN]    = neg_en_r;
         rdata_nxt[`LNK_CTL_NPO]       = npo_r;
         rdata_nxt[`LNK_CTL_FORCE_FDX] = force_fdx_r;
      end else if (hit(reg_addr, `LNK_OFF_STAT)) begin
         rdata_nxt = {10'h000, `LNK_ID_STAT};
         rdata_nxt[`LNK_ST_BUSY]  = busy;
         rdata_nxt[`LNK_ST_BURST] = burst_seen_r;
         rdata_nxt[`LNK_ST_DONE]  = done_r;
         rdata_nxt[`LNK_ST_LOST]  = lost_r;
         rdata_nxt[`LNK_ST_HDX]   = hdx_r;
         rdata_nxt[`LNK_ST_FDX]   = fdx_r;
      end
   end

   // Read data is captured on the strobe and then held.
   // The reflectometer count is captured on the same edge that clears it; the tick
   // of that edge is lost, as the count restarts from zero rather than one.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end
   end

endmodule // lnk_top

// ==== src/lnk_defs.vh ====
// Constants for the link negotiation and AUI reflectometer block.
`ifndef LNK_DEFS_VH
`define LNK_DEFS_VH

// Register offsets on the register port.
`define LNK_OFF_CTRL        16'h011c
`define LNK_OFF_TDR         16'h013c
`define LNK_OFF_STAT        16'h013e

// Reset values, which are also the fixed identifying codes.
`define LNK_RST_CTRL        16'h001d
`define LNK_RST_TDR         16'h001c
`define LNK_RST_STAT        16'h001e
`define LNK_ID_CTRL         6'h1d
`define LNK_ID_TDR          6'h1c
`define LNK_ID_STAT         6'h1e

// Control field positions.
`define LNK_CTL_RESTART     6
`define LNK_CTL_ADV_FDX     7
`define LNK_CTL_NEG_EN      8
`define LNK_CTL_NPO         9
`define LNK_CTL_FORCE_FDX   15

// Status field positions.
`define LNK_ST_BUSY         7
`define LNK_ST_BURST        8
`define LNK_ST_DONE         11
`define LNK_ST_LOST         12
`define LNK_ST_HDX          14
`define LNK_ST_FDX          15

// Reflectometer count field.
`define LNK_TDR_LSB         6
`define LNK_TDR_W           10
`define LNK_TDR_MAX         10'h03ff

// Count rate and clock rate in Hz; the count advances once per clock cycle.
`define LNK_TDR_RATE_HZ     10000000
`define LNK_CLK_HZ          10000000
`define LNK_TDR_DIV         (`LNK_CLK_HZ / `LNK_TDR_RATE_HZ)

// Bursts needed in ability detect before acknowledging the partner.
`define LNK_BURSTS_NEEDED   3'h3

`endif

// ==== src/lnk_tdr.v ====
// Saturating AUI cable-fault reflectometer counter.
`timescale 1ns/1ps
`include "lnk_defs.vh"
module lnk_tdr (
   input  wire                   clk_sys,   // System clock, 10 MHz.
   input  wire                   rst_n,     // Asynchronous reset, active low.
   input  wire                   start_p,   // Pulse: AUI transmission begins.
   input  wire                   stop_p,    // Pulse: collision or loss of carrier.
   input  wire                   clear_p,   // Pulse: host read of the counter register.
   output wire [`LNK_TDR_W-1:0]  count      // Current count.
);

   reg                  run_r;
   reg                  run_nxt;
   reg [`LNK_TDR_W-1:0] cnt_r;
   reg [`LNK_TDR_W-1:0] cnt_nxt;

   // Start restarts from zero; stop freezes the count until read. Stop wins over
   // start in the same cycle, since the fault has already been seen.
   always @* begin
      run_nxt = run_r;
      cnt_nxt = cnt_r;
      if (clear_p) begin
         cnt_nxt = {`LNK_TDR_W{1'b0}};
      end
      if (start_p) begin
         run_nxt = 1'b1;
         cnt_nxt = {`LNK_TDR_W{1'b0}};
      end else if (run_r && !clear_p && cnt_r != `LNK_TDR_MAX) begin
         cnt_nxt = cnt_r + 10'h001;
      end
      if (stop_p) begin
         run_nxt = 1'b0;
      end
   end

   // State flops.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         run_r <= 1'b0;
         cnt_r <= {`LNK_TDR_W{1'b0}};
      end else begin
         run_r <= run_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign count = cnt_r;

endmodule // lnk_tdr

// ==== dv/lnk_top_sva.sv ====
// Port-level assertions for the link negotiation and reflectometer block.
`timescale 1ns/1ps
`include "lnk_defs.vh"
module lnk_top_sva (
   input wire        clk_sys,              // System clock.
   input wire        rst_n,                // Reset, active low.
   input wire [15:0] reg_addr,             // Register offset.
   input wire        reg_rd,               // Read strobe.
   input wire        reg_wr,               // Write strobe.
   input wire [15:0] reg_wdata,            // Write data.
   input wire [15:0] reg_rdata,            // Read data.
   input wire        nlp_tx_en,            // Normal pulses on.
   input wire        flp_tx_en,            // Fast bursts on.
   input wire        tx_enable,            // Transmitter on.
   input wire        adv_fdx_out,          // Advertised full duplex.
   input wire        duplex_indicator_out  // Full duplex indicator.
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   // Decoded accesses, shared by the properties below.
   wire rd_cnt = reg_rd && (reg_addr == `LNK_OFF_TDR);
   wire rd_ctl = reg_rd && (reg_addr == `LNK_OFF_CTRL);
   wire rd_st  = reg_rd && (reg_addr == `LNK_OFF_STAT);
   wire wr_ctl = reg_wr && (reg_addr == `LNK_OFF_CTRL);

   chk_id_counter: assert property (rd_cnt |=> reg_rdata[5:0] == 6'h1c)
      else $error("counter register code wrong");
   chk_id_control: assert property (rd_ctl |=> reg_rdata[5:0] == 6'h1d)
      else $error("control register code wrong");
   chk_id_status: assert property (rd_st |=> reg_rdata[5:0] == 6'h1e)
      else $error("status register code wrong");
   chk_duplex_exclusive: assert property (rd_st |=> !(reg_rdata[15] && reg_rdata[14]))
      else $error("both duplex bits set");
   // Both sides of the compare are registered, so only judge when the indicator sat still.
   chk_indicator_status: assert property (rd_st && $stable(duplex_indicator_out) ##1
      $stable(duplex_indicator_out) |-> reg_rdata[15] == duplex_indicator_out)
      else $error("indicator differs from full duplex status");
   chk_pulse_only: assert property (wr_ctl && reg_wdata[9] && !reg_wdata[15]
      |-> ##[1:3] (nlp_tx_en && !flp_tx_en && tx_enable))
      else $error("normal pulse mode not entered");
   chk_force_full: assert property (wr_ctl && reg_wdata[15]
      |-> ##[1:3] (duplex_indicator_out && !flp_tx_en))
      else $error("forced full duplex not shown");
   // State leaves OFF one edge after the write, the burst enable one edge later.
   chk_neg_start: assert property (wr_ctl && reg_wdata[8]
      && !reg_wdata[9] && !reg_wdata[15] |-> ##3 flp_tx_en)
      else $error("bursts not started");
   chk_all_quiet: assert property (wr_ctl && !reg_wdata[8]
      && !reg_wdata[9] && !reg_wdata[15] |-> ##[1:3] (!flp_tx_en && !nlp_tx_en && !tx_enable))
      else $error("pulses or transmitter left on");

   cov_neg: cover property (wr_ctl && reg_wdata[8] ##2 flp_tx_en);
   cov_sat: cover property (rd_cnt ##1 reg_rdata[15:6] == 10'h3ff);
   cov_fdx: cover property (duplex_indicator_out && adv_fdx_out);
endmodule // lnk_top_sva

bind lnk_top lnk_top_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .nlp_tx_en(nlp_tx_en), .flp_tx_en(flp_tx_en), .tx_enable(tx_enable),
   .adv_fdx_out(adv_fdx_out), .duplex_indicator_out(duplex_indicator_out));

// ==== dv/lnk_link_partner.sv ====
// Behavioural model of the remote twisted-pair link partner.
`timescale 1ns/1ps
module lnk_link_partner (
   input  wire clk_sys,         // System clock.
   input  wire flp_tx_en,       // Local side sends bursts.
   input  wire go,              // Partner present on the wire.
   input  wire fdx_cap,         // Partner can run full duplex.
   output reg  flp_burst_in,    // High once per burst.
   output reg  partner_fdx_in,  // Advertised full duplex.
   output reg  link_good_in     // Link judged good.
);
   reg [5:0] tick_r;
   initial begin
      tick_r = 6'h00;
      flp_burst_in = 1'b0;
      partner_fdx_in = 1'b0;
      link_good_in = 1'b0;
   end
   // Five bursts eight cycles apart, then the link is called good; a missing partner says nothing.
   always @(posedge clk_sys) begin
      if (!go) begin
         tick_r <= 6'h00;
         flp_burst_in <= 1'b0;
         link_good_in <= 1'b0;
      end else if (flp_tx_en || link_good_in) begin
         tick_r <= tick_r + {5'h00, tick_r != 6'h3f};
         flp_burst_in <= tick_r[2] && (tick_r < 6'd40);
         link_good_in <= tick_r >= 6'd40;
      end
      partner_fdx_in <= go && fdx_cap;
   end
endmodule // lnk_link_partner

// ==== dv/lnk_top_tb.sv ====
// Self-checking bench for the link negotiation and reflectometer block.
`timescale 1ns/1ps
`include "lnk_defs.vh"
module lnk_top_tb;
   reg clk_sys = 1'b0;
   reg rst_n = 1'b0;
   reg [15:0] reg_addr = 16'h0000;
   reg reg_rd = 1'b0;
   reg reg_wr = 1'b0;
   reg [15:0] reg_wdata = 16'h0000;
   reg [2:0] aui = 3'b000;
   reg pgo = 1'b0;
   reg pfdx = 1'b0;
   wire [15:0] reg_rdata;
   wire flp_b, p_fdx, l_good, nlp_tx_en, flp_tx_en, tx_enable, adv_fdx_out, dup_out;
   int mismatches = 0;
   int n_checks = 0;
   reg [51:0] rows [0:4];
   reg [31:0] rst_rows [0:3];
   reg [15:0] d;
   int i;

   always #50 clk_sys = ~clk_sys;

   lnk_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .flp_burst_in(flp_b),
      .partner_fdx_in(p_fdx), .link_good_in(l_good), .aui_tx_in(aui[0]),
      .aui_collision_in(aui[1]), .aui_carrier_loss_in(aui[2]), .nlp_tx_en(nlp_tx_en),
      .flp_tx_en(flp_tx_en), .tx_enable(tx_enable), .adv_fdx_out(adv_fdx_out),
      .duplex_indicator_out(dup_out));
   lnk_link_partner u_partner (.clk_sys(clk_sys), .flp_tx_en(flp_tx_en), .go(pgo),
      .fdx_cap(pfdx), .flp_burst_in(flp_b), .partner_fdx_in(p_fdx), .link_good_in(l_good));

   // Masked compare; an unknown bit never passes.
   task automatic chk(input [15:0] g, input [15:0] e, input [15:0] m);
      n_checks = n_checks + 1;
      if ((g & m) !== (e & m)) begin
         mismatches = mismatches + 1;
         $display("ERROR %0t got %h expected %h mask %h", $time, g, e, m);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic wr(input [15:0] a, input [15:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // Read data lands on the edge that takes the strobe.
   task automatic rd(input [15:0] a, output [15:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wait_st(input [15:0] e, input [15:0] m);
      reg [15:0] v;
      int k;
      for (k = 0; k < 300; k++) begin
         rd(`LNK_OFF_STAT, v);
         if ((v & m) === (e & m)) break;
      end
      chk(v, e, m);
      if (k == 300) tally_and_finish;
   endtask
   // Pulse held a few cycles so the input synchronisers see a clean edge.
   task automatic aui_pulse(input [2:0] v);
      @(posedge clk_sys);
      aui <= v;
      repeat (3) @(posedge clk_sys);
      aui <= 3'b000;
   endtask
   task automatic reset_rows;
      for (i = 0; i < 4; i++) begin
         rd(rst_rows[i][31:16], d);
         chk(d, rst_rows[i][15:0], 16'hffff);
      end
   endtask
   // Twenty-one cycles between the start and stop pin edges; both see the same sync delay.
   task automatic count_run(input [2:0] stop);
      aui_pulse(3'b001);
      repeat (17) @(posedge clk_sys);
      aui_pulse(stop);
      repeat (4) @(posedge clk_sys);
      rd(`LNK_OFF_TDR, d);
      chk(d, 16'h055c, 16'hffff);
      rd(`LNK_OFF_TDR, d);
      chk(d, 16'h001c, 16'hffff);
   endtask

   initial begin
      // Rows: control word, {nlp, flp, tx, indicator}, status expected, status mask.
      rows[0] = {16'h0000, 4'b0000, 16'h001e, 16'hc0bf};
      rows[1] = {16'h8000, 4'b1011, 16'h801e, 16'hc0bf};
      rows[2] = {16'h8200, 4'b1011, 16'h801e, 16'hc0bf};
      rows[3] = {16'h0200, 4'b1010, 16'h401e, 16'hc0bf};
      rows[4] = {16'h0100, 4'b0110, 16'h009e, 16'h00bf};
      rst_rows[0] = {`LNK_OFF_CTRL, 16'h001d};
      rst_rows[1] = {`LNK_OFF_TDR, 16'h001c};
      rst_rows[2] = {`LNK_OFF_STAT, 16'h001e};
      rst_rows[3] = {16'h0120, 16'h0000};
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      reset_rows;
      for (int r = 0; r < 5; r++) begin
         wr(`LNK_OFF_CTRL, rows[r][51:36]);
         repeat (4) @(posedge clk_sys);
         chk({12'h000, nlp_tx_en, flp_tx_en, tx_enable, dup_out}, {12'h000, rows[r][35:32]},
            16'h000f);
         rd(`LNK_OFF_CTRL, d);
         chk(d, rows[r][51:36] | 16'h001d, 16'h83bf);
         rd(`LNK_OFF_STAT, d);
         chk(d, rows[r][31:16], rows[r][15:0]);
      end
      // Full duplex partner, advertising on.
      wr(`LNK_OFF_CTRL, 16'h01c0);
      pfdx <= 1'b1;
      pgo <= 1'b1;
      wait_st(16'h891e, 16'hc9bf);
      chk({14'h0000, dup_out, adv_fdx_out}, 16'h0003, 16'h0003);
      wr(`LNK_OFF_CTRL, 16'h0100);
      repeat (4) @(posedge clk_sys);
      chk({15'h0000, adv_fdx_out}, 16'h0001, 16'h0001);
      pgo <= 1'b0;
      wait_st(16'h1080, 16'h1080);
      wr(`LNK_OFF_CTRL, 16'h0140);
      rd(`LNK_OFF_STAT, d);
      chk(d, 16'h1000, 16'h9900);
      pfdx <= 1'b0;
      pgo <= 1'b1;
      wait_st(16'h4800, 16'hc800);
      chk({15'h0000, adv_fdx_out}, 16'h0000, 16'h0001);
      rd(`LNK_OFF_CTRL, d);
      chk(d, 16'h011d, 16'h83ff);
      // Abort from ability detect, setting restart as software should.
      pgo <= 1'b0;
      wait_st(16'h0080, 16'h0080);
      wr(`LNK_OFF_CTRL, 16'h0040);
      repeat (4) @(posedge clk_sys);
      chk({13'h0000, nlp_tx_en, flp_tx_en, tx_enable}, 16'h0000, 16'h0007);
      rd(`LNK_OFF_STAT, d);
      chk(d, 16'h001e, 16'h00bf);
      count_run(3'b010);
      count_run(3'b100);
      // Long interval: the count must pin at its top value.
      aui_pulse(3'b001);
      repeat (1100) @(posedge clk_sys);
      aui_pulse(3'b100);
      repeat (4) @(posedge clk_sys);
      rd(`LNK_OFF_TDR, d);
      chk(d, 16'hffdc, 16'hffff);
      rd(`LNK_OFF_TDR, d);
      chk(d, 16'h001c, 16'hffff);
      // Second reset mid-run, with forced full duplex active.
      wr(`LNK_OFF_CTRL, 16'h8000);
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      reset_rows;
      chk({15'h0000, dup_out}, 16'h0000, 16'h0001);
      tally_and_finish;
   end
endmodule // lnk_top_tb
